// File: design/flst_consts.svh
/*
  Constants of the last-instruction state tracker: widths, field
  positions, reset values. Assumes inclusion by bare name only.
*/
`ifndef FLST_CONSTS_SVH
`define FLST_CONSTS_SVH

`define FLST_OFF_W          64
`define FLST_OFF_LO_W       32
`define FLST_SEL_W          16
`define FLST_OPC_W          11
`define FLST_OPC_LO_W       3
`define FLST_OPC_BYTE_W     8
`define FLST_OPC_HI_PAT     5'h1B
`define FLST_MISC_W         64
`define FLST_MISC_COMPAT_BIT 2
`define FLST_OP_W           4
`define FLST_OFF_RST        64'h0000000000000000
`define FLST_SEL_RST        16'h0000
`define FLST_OPC_RST        11'h000
`define FLST_SEL_DEPR_VAL   16'h0000
`define FLST_COMPAT_RST     1'b0

`endif

// File: design/flst_pkg.sv
/*
  Types of the last-instruction state tracker: operation codes,
  image formats and the pointer and image carriers.
  Assumes flst_consts.svh is on the include path.
*/
`include "flst_consts.svh"

package flst_pkg;

  typedef enum logic [`FLST_OP_W-1:0] {
    FLST_OP_NONE      = 4'h0,
    FLST_OP_INIT      = 4'h1,
    FLST_OP_ENV_LOAD  = 4'h2,
    FLST_OP_FULL_RST  = 4'h3,
    FLST_OP_ENV_STORE = 4'h4,
    FLST_OP_FULL_SAVE = 4'h5,
    FLST_OP_XRST      = 4'h6,
    FLST_OP_XRST_ALT  = 4'h7,
    FLST_OP_EXTENDED_SAVE_ALT_OP     = 4'h8,
    FLST_OP_EXTENDED_SAVE_ALT_OP_ALT = 4'h9,
    FLST_OP_EXTENDED_SAVE_ALT_OP_OPT = 4'hA,
    FLST_OP_CLEX      = 4'hB,
    FLST_OP_LDCW      = 4'hC,
    FLST_OP_STCW      = 4'hD,
    FLST_OP_STSW      = 4'hE,
    FLST_OP_WAIT      = 4'hF
  } flst_op_t;

  typedef enum logic [1:0] {
    FLST_FMT_PROT32 = 2'h0,
    FLST_FMT_PROT16 = 2'h1,
    FLST_FMT_REAL32 = 2'h2,
    FLST_FMT_REAL16 = 2'h3
  } flst_fmt_t;

  typedef struct packed {
    logic [`FLST_SEL_W-1:0] sel;
    logic [`FLST_OFF_W-1:0] off;
  } flst_ptr_t;

  typedef struct packed {
    flst_ptr_t              code;
    flst_ptr_t              opnd;
    logic [`FLST_OPC_W-1:0] opcode;
  } flst_img_t;

  typedef struct packed {
    logic                       ctrl;
    logic                       has_mem;
    logic                       unmasked_exc;
    flst_ptr_t                  code;
    flst_ptr_t                  opnd;
    logic [`FLST_OPC_BYTE_W-1:0] opc_first;
    logic [`FLST_OPC_BYTE_W-1:0] opc_second;
  } flst_retire_t;

  typedef struct packed {
    logic pe;
    logic mode64;
    logic wide;
    logic v86;
    logic system_management_mode;
    logic osize32;
  } flst_mode_t;

endpackage

// File: design/flst_tracker.sv
/*
  Last-instruction state tracker of the floating-point unit: holds
  the code and operand pointers and the compressed opcode, and applies
  the init, load, store, save and restore operations to them.
  Assumes all inputs come from execution logic on CORE_CLK, that at
  most one operation is presented per cycle, and that the memory
  side accepts a save image in the cycle SAVE_VALID is high.
*/
// Contract
// [RULE1] capture both pointers of each completing non-control instruction
// [RULE2] operand pointer refers to memory; undefined without memory operand
// [RULE3] clear, control-word, status, env store, wait leave pointers
// [RULE4] code pointer points at the first prefix byte
// [RULE5] offsets are 64 bits, selectors 16 bits
// [RULE6] init clears both offsets and selectors
// [RULE7] env load and full restore load low 32 bits, zero upper
// [RULE8] env load and full restore load selectors if protected, else zero
// [RULE9] env store and full save write only low 32 offset bits
// [RULE10] selectors saved as zero when deprecation feature bit is set
// [RULE11] env store and full save write selectors only when protected
// [RULE12] full save clears offsets and selectors after writing image
// [RULE13] narrow extended restore loads low 32 bits and selectors
// [RULE14] wide 64-bit extended restore loads full offsets, clears selectors
// [RULE15] narrow extended save stores low 32 bits and selectors
// [RULE16] wide 64-bit extended save stores full offsets, no selectors
// [RULE17] opcode is 11 bits: low 3 of first byte plus second byte
// [RULE18] compatibility sub-mode follows bit 2 of misc enable register
// [RULE19] compatibility on: saved opcode is always the last one
// [RULE20] compatibility off: opcode valid only after unmasked exception
// [RULE21] env store writes environment; full save adds data, reinitialises
// [RULE22] env load restores environment; full restore adds data stack
// [RULE23] image format from protection and operand size; v86, smm real
// [RULE24] pointers and opcode update together in the completing cycle
`timescale 1ns/100ps
`include "flst_consts.svh"

module flst_tracker (
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST_B,
  input  wire logic                     RET_VALID,
  input  flst_pkg::flst_retire_t        RET_INFO,
  input  wire logic                     OP_VALID,
  input  flst_pkg::flst_op_t            OP_CODE,
  input  flst_pkg::flst_mode_t          OP_MODE,
  input  flst_pkg::flst_img_t           LOAD_IMG,
  input  wire logic                     SEL_DEPRECATE,
  input  wire logic                     MISC_WR,
  input  wire logic [`FLST_MISC_W-1:0]  MISC_WDATA,
  output flst_pkg::flst_img_t           STATE,
  output logic                          COMPAT_MODE,
  output logic                          SAVE_VALID,
  output flst_pkg::flst_img_t           SAVE_IMG,
  output flst_pkg::flst_fmt_t           SAVE_FMT,
  output logic                          SAVE_OFF_HI,
  output logic                          SAVE_SEL,
  output logic                          SAVE_OPC_VALID,
  output logic                          SAVE_DATA_REGS,
  output logic                          LOAD_DATA_REGS,
  output logic                          INIT_UNIT
);

  ////////////////////////////////////////////////////////////////////////
  // architectural state

  flst_pkg::flst_img_t  state_r;
  flst_pkg::flst_img_t  state_nxt;
  logic                 exc_r;
  logic                 exc_nxt;
  logic                 compat_r;

  ////////////////////////////////////////////////////////////////////////
  // operation decode

  logic is_init;
  logic is_env_load;
  logic is_full_rst;
  logic is_env_store;
  logic is_full_save;
  logic is_xrst;
  logic is_extended_save_alt_op;
  logic wide64;
  logic legacy_load;
  logic legacy_save;
  logic any_save;

  always_comb begin
    is_init      = OP_VALID && (OP_CODE == flst_pkg::FLST_OP_INIT);
    is_env_load  = OP_VALID && (OP_CODE == flst_pkg::FLST_OP_ENV_LOAD);
    is_full_rst  = OP_VALID && (OP_CODE == flst_pkg::FLST_OP_FULL_RST);
    is_env_store = OP_VALID && (OP_CODE == flst_pkg::FLST_OP_ENV_STORE);
    is_full_save = OP_VALID && (OP_CODE == flst_pkg::FLST_OP_FULL_SAVE);
    is_xrst      = OP_VALID && ((OP_CODE == flst_pkg::FLST_OP_XRST) ||
                   (OP_CODE == flst_pkg::FLST_OP_XRST_ALT));
    is_extended_save_alt_op     = OP_VALID && ((OP_CODE == flst_pkg::FLST_OP_EXTENDED_SAVE_ALT_OP) ||
                   (OP_CODE == flst_pkg::FLST_OP_EXTENDED_SAVE_ALT_OP_ALT) ||
                   (OP_CODE == flst_pkg::FLST_OP_EXTENDED_SAVE_ALT_OP_OPT));
    // full-width form needs both the 64-bit mode and the width prefix
    wide64       = OP_MODE.mode64 && OP_MODE.wide;
    legacy_load  = is_env_load || is_full_rst;
    legacy_save  = is_env_store || is_full_save;
    any_save     = legacy_save || is_extended_save_alt_op;
  end

  ////////////////////////////////////////////////////////////////////////
  // image offset and selector shaping

  function automatic logic [`FLST_OFF_W-1:0] low_only(
    input logic [`FLST_OFF_W-1:0] off
  );
    low_only = {{(`FLST_OFF_W-`FLST_OFF_LO_W){1'b0}},
                off[`FLST_OFF_LO_W-1:0]};
  endfunction

  function automatic logic [`FLST_SEL_W-1:0] sel_out(
    input logic [`FLST_SEL_W-1:0] sel,
    input logic                   keep,
    input logic                   depr
  );
    if (!keep || depr) begin
      sel_out = `FLST_SEL_DEPR_VAL;
    end else begin
      sel_out = sel;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state: an operation outranks a retiring instruction

  always_comb begin
    state_nxt = state_r;
    exc_nxt   = exc_r;
    if (is_init || is_full_save) begin
      state_nxt.code.off = `FLST_OFF_RST; // [RULE6] [RULE12]
      state_nxt.code.sel = `FLST_SEL_RST; // [RULE6] [RULE12]
      state_nxt.opnd.off = `FLST_OFF_RST; // [RULE6] [RULE12]
      state_nxt.opnd.sel = `FLST_SEL_RST; // [RULE6] [RULE12]
      state_nxt.opcode   = `FLST_OPC_RST;
      exc_nxt            = 1'b0;
    end else if (legacy_load) begin
      // environment only; data registers are restored elsewhere
      state_nxt.code.off = low_only(LOAD_IMG.code.off); // [RULE7]
      state_nxt.opnd.off = low_only(LOAD_IMG.opnd.off); // [RULE7]
      state_nxt.code.sel = OP_MODE.pe ?
                           LOAD_IMG.code.sel : `FLST_SEL_RST; // [RULE8]
      state_nxt.opnd.sel = OP_MODE.pe ?
                           LOAD_IMG.opnd.sel : `FLST_SEL_RST; // [RULE8]
      state_nxt.opcode   = LOAD_IMG.opcode; // [RULE22]
      exc_nxt            = 1'b0;
    end else if (is_xrst) begin
      if (wide64) begin
        state_nxt.code.off = LOAD_IMG.code.off; // [RULE14]
        state_nxt.opnd.off = LOAD_IMG.opnd.off; // [RULE14]
        state_nxt.code.sel = `FLST_SEL_RST; // [RULE14]
        state_nxt.opnd.sel = `FLST_SEL_RST; // [RULE14]
      end else begin
        state_nxt.code.off = low_only(LOAD_IMG.code.off); // [RULE13]
        state_nxt.opnd.off = low_only(LOAD_IMG.opnd.off); // [RULE13]
        state_nxt.code.sel = LOAD_IMG.code.sel; // [RULE13]
        state_nxt.opnd.sel = LOAD_IMG.opnd.sel; // [RULE13]
      end
      state_nxt.opcode = LOAD_IMG.opcode;
      exc_nxt          = 1'b0;
    end else if (OP_VALID) begin
      // stores and transparent control ops leave the pointers alone
      state_nxt = state_r; // [RULE3]
    end else if (RET_VALID && !RET_INFO.ctrl) begin
      // one cycle for all three so a save never sees a mix
      state_nxt.code = RET_INFO.code; // [RULE1] [RULE4] [RULE5] [RULE24]
      if (RET_INFO.has_mem) begin
        // without a memory operand the old value stays; it is undefined
        state_nxt.opnd = RET_INFO.opnd; // [RULE1] [RULE2] [RULE24]
      end
      state_nxt.opcode = {RET_INFO.opc_first[`FLST_OPC_LO_W-1:0],
                          RET_INFO.opc_second}; // [RULE17] [RULE24]
      exc_nxt = RET_INFO.unmasked_exc; // [RULE20]
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_r.code.off <= `FLST_OFF_RST;
      state_r.code.sel <= `FLST_SEL_RST;
      state_r.opnd.off <= `FLST_OFF_RST;
      state_r.opnd.sel <= `FLST_SEL_RST;
      state_r.opcode   <= `FLST_OPC_RST;
      exc_r            <= 1'b0;
    end else begin
      state_r <= state_nxt;
      exc_r   <= exc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compatibility sub-mode control

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      compat_r <= `FLST_COMPAT_RST;
    end else if (MISC_WR) begin
      compat_r <= MISC_WDATA[`FLST_MISC_COMPAT_BIT]; // [RULE18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // save image: built from the state before this cycle's clearing

  flst_pkg::flst_img_t  save_nxt;
  flst_pkg::flst_fmt_t  fmt_nxt;
  logic                 off_hi_nxt;
  logic                 sel_wr_nxt;
  logic                 real_fmt;

  always_comb begin
    save_nxt   = state_r;
    off_hi_nxt = 1'b0;
    sel_wr_nxt = 1'b0;
    // v86 and system management use the real-address layout
    real_fmt   = !OP_MODE.pe || OP_MODE.v86 || OP_MODE.system_management_mode; // [RULE23]
    if (real_fmt) begin
      fmt_nxt = OP_MODE.osize32 ? flst_pkg::FLST_FMT_REAL32 :
                flst_pkg::FLST_FMT_REAL16; // [RULE23]
    end else begin
      fmt_nxt = OP_MODE.osize32 ? flst_pkg::FLST_FMT_PROT32 :
                flst_pkg::FLST_FMT_PROT16; // [RULE23]
    end
    if (legacy_save) begin
      save_nxt.code.off = low_only(state_r.code.off); // [RULE9]
      save_nxt.opnd.off = low_only(state_r.opnd.off); // [RULE9]
      sel_wr_nxt        = OP_MODE.pe; // [RULE11]
      save_nxt.code.sel = sel_out(state_r.code.sel, OP_MODE.pe,
                                  SEL_DEPRECATE); // [RULE10] [RULE11]
      save_nxt.opnd.sel = sel_out(state_r.opnd.sel, OP_MODE.pe,
                                  SEL_DEPRECATE); // [RULE10] [RULE11]
    end else if (is_extended_save_alt_op && wide64) begin
      off_hi_nxt        = 1'b1; // [RULE16]
      save_nxt.code.sel = `FLST_SEL_RST; // [RULE16]
      save_nxt.opnd.sel = `FLST_SEL_RST; // [RULE16]
    end else if (is_extended_save_alt_op) begin
      save_nxt.code.off = low_only(state_r.code.off); // [RULE15]
      save_nxt.opnd.off = low_only(state_r.opnd.off); // [RULE15]
      sel_wr_nxt        = 1'b1; // [RULE15]
      save_nxt.code.sel = sel_out(state_r.code.sel, 1'b1,
                                  SEL_DEPRECATE); // [RULE10] [RULE15]
      save_nxt.opnd.sel = sel_out(state_r.opnd.sel, 1'b1,
                                  SEL_DEPRECATE); // [RULE10] [RULE15]
    end
  end

  flst_pkg::flst_img_t  save_img_r;
  flst_pkg::flst_fmt_t  save_fmt_r;
  logic                 save_valid_r;
  logic                 save_off_hi_r;
  logic                 save_sel_r;
  logic                 save_opc_valid_r;
  logic                 save_data_r;
  logic                 load_data_r;
  logic                 init_unit_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      save_img_r.code.off <= `FLST_OFF_RST;
      save_img_r.code.sel <= `FLST_SEL_RST;
      save_img_r.opnd.off <= `FLST_OFF_RST;
      save_img_r.opnd.sel <= `FLST_SEL_RST;
      save_img_r.opcode   <= `FLST_OPC_RST;
      save_fmt_r          <= flst_pkg::FLST_FMT_PROT32;
      save_off_hi_r       <= 1'b0;
      save_sel_r          <= 1'b0;
      save_opc_valid_r    <= 1'b0;
    end else if (any_save) begin
      // image holds until the next save
      save_img_r       <= save_nxt;
      save_fmt_r       <= fmt_nxt;
      save_off_hi_r    <= off_hi_nxt;
      save_sel_r       <= sel_wr_nxt;
      save_opc_valid_r <= compat_r || exc_r; // [RULE19] [RULE20]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one-cycle strobes toward the memory side and the rest of the unit

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      save_valid_r <= 1'b0;
      save_data_r  <= 1'b0;
      load_data_r  <= 1'b0;
      init_unit_r  <= 1'b0;
    end else begin
      save_valid_r <= any_save; // [RULE21]
      save_data_r  <= is_full_save; // [RULE21]
      load_data_r  <= is_full_rst; // [RULE22]
      // control, status and tag reset happen outside on this strobe
      init_unit_r  <= is_init || is_full_save; // [RULE21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    STATE          = state_r;
    COMPAT_MODE    = compat_r;
    SAVE_VALID     = save_valid_r;
    SAVE_IMG       = save_img_r;
    SAVE_FMT       = save_fmt_r;
    SAVE_OFF_HI    = save_off_hi_r;
    SAVE_SEL       = save_sel_r;
    SAVE_OPC_VALID = save_opc_valid_r;
    SAVE_DATA_REGS = save_data_r;
    LOAD_DATA_REGS = load_data_r;
    INIT_UNIT      = init_unit_r;
  end

endmodule // flst_tracker

// File: bench/flst_tracker_monitor.sv
/* Port checker for the state tracker, bound to flst_tracker.
   Assumes flst_pkg is compiled first, one clock, sync reset. */
`timescale 1ns/100ps
`include "flst_consts.svh"
module flst_tracker_mon (
  input wire logic                    CORE_CLK,
  input wire logic                    RST_B,
  input wire logic                    RET_VALID,
  input flst_pkg::flst_retire_t       RET_INFO,
  input wire logic                    OP_VALID,
  input flst_pkg::flst_op_t           OP_CODE,
  input flst_pkg::flst_mode_t         OP_MODE,
  input flst_pkg::flst_img_t          LOAD_IMG,
  input wire logic                    SEL_DEPRECATE,
  input wire logic                    MISC_WR,
  input wire logic [`FLST_MISC_W-1:0] MISC_WDATA,
  input flst_pkg::flst_img_t          STATE,
  input wire logic                    COMPAT_MODE,
  input wire logic                    SAVE_VALID,
  input flst_pkg::flst_img_t          SAVE_IMG,
  input flst_pkg::flst_fmt_t          SAVE_FMT,
  input wire logic                    SAVE_OFF_HI,
  input wire logic                    SAVE_SEL,
  input wire logic                    SAVE_OPC_VALID,
  input wire logic                    SAVE_DATA_REGS,
  input wire logic                    LOAD_DATA_REGS,
  input wire logic                    INIT_UNIT
);
  ////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  // opcode gated by valid, so idle cycles never match an operation
  wire logic [3:0] oc  = OP_VALID ? OP_CODE : 4'h0;
  wire logic       sv  = oc == 4'h4 || oc == 4'h5;
  wire logic       xs  = oc >= 4'h8 && oc <= 4'hA;
  wire logic       w64 = OP_MODE.mode64 && OP_MODE.wide;
  sequence s_save_req;
    oc == 4'h5;
  endsequence
  sequence s_save_done;
    SAVE_VALID && SAVE_DATA_REGS && INIT_UNIT;
  endsequence
  chk_ret_capture: assert property (
    RET_VALID && !RET_INFO.ctrl && !OP_VALID |=> STATE.code ==
    $past(RET_INFO.code) && STATE.opcode == {$past(RET_INFO.opc_first[2:0]),
    $past(RET_INFO.opc_second)} && (!$past(RET_INFO.has_mem) ||
    STATE.opnd == $past(RET_INFO.opnd))) else $error("retire not captured");
  chk_ctrl_hold: assert property (
    RET_VALID && RET_INFO.ctrl && !OP_VALID |=> $stable(STATE))
    else $error("control instruction changed state");
  chk_transp_hold: assert property (
    oc >= 4'hB || oc == 4'h4 |=> STATE.code == $past(STATE.code) &&
    STATE.opnd == $past(STATE.opnd)) else $error("pointers disturbed");
  chk_init_clear: assert property (
    oc == 4'h1 |=> STATE == '0 && INIT_UNIT) else $error("init left state");
  chk_env_load: assert property (
    oc == 4'h2 || oc == 4'h3 |=> STATE.code.off == {32'h0,
    $past(LOAD_IMG.code.off[31:0])} && STATE.opnd.sel == ($past(OP_MODE.pe) ?
    $past(LOAD_IMG.opnd.sel) : 16'h0) && LOAD_DATA_REGS == ($past(oc) == 4'h3))
    else $error("environment load misshaped");
  chk_xrst_load: assert property (
    oc == 4'h6 || oc == 4'h7 |=> STATE.code.off == ($past(w64) ?
    $past(LOAD_IMG.code.off) : {32'h0, $past(LOAD_IMG.code.off[31:0])}) &&
    STATE.opnd.sel == ($past(w64) ? 16'h0 : $past(LOAD_IMG.opnd.sel)))
    else $error("extended restore misshaped");
  chk_legacy_save: assert property (
    sv |=> SAVE_VALID && !SAVE_OFF_HI && SAVE_SEL == $past(OP_MODE.pe) &&
    SAVE_IMG.code.off == {32'h0, $past(STATE.code.off[31:0])})
    else $error("legacy save misshaped");
  chk_sel_deprec: assert property (
    (sv || xs) && SEL_DEPRECATE |=> SAVE_IMG.code.sel == 16'h0 &&
    SAVE_IMG.opnd.sel == 16'h0) else $error("deprecated selector saved");
  chk_extended_save_alt_op_shape: assert property (
    xs |=> SAVE_VALID && SAVE_OFF_HI == $past(w64) && SAVE_SEL != $past(w64)
    && SAVE_IMG.opnd.off == ($past(w64) ? $past(STATE.opnd.off) :
    {32'h0, $past(STATE.opnd.off[31:0])})) else $error("extended_save_alt_op misshaped");
  chk_full_save: assert property (
    s_save_req |=> s_save_done ##0 STATE == '0)
    else $error("full save did not reinitialise");
  chk_compat_wr: assert property (
    MISC_WR |=> COMPAT_MODE == $past(MISC_WDATA[`FLST_MISC_COMPAT_BIT]))
    else $error("compatibility bit not taken");
  chk_save_fmt: assert property (
    sv || xs |=> SAVE_FMT == {$past(!OP_MODE.pe || OP_MODE.v86 ||
    OP_MODE.system_management_mode), $past(!OP_MODE.osize32)}) else $error("wrong format");
endmodule // flst_tracker_mon

bind flst_tracker flst_tracker_mon i_mon (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .RET_VALID(RET_VALID),
  .RET_INFO(RET_INFO), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
  .OP_MODE(OP_MODE), .LOAD_IMG(LOAD_IMG), .SEL_DEPRECATE(SEL_DEPRECATE),
  .MISC_WR(MISC_WR), .MISC_WDATA(MISC_WDATA), .STATE(STATE),
  .COMPAT_MODE(COMPAT_MODE), .SAVE_VALID(SAVE_VALID), .SAVE_IMG(SAVE_IMG),
  .SAVE_FMT(SAVE_FMT), .SAVE_OFF_HI(SAVE_OFF_HI), .SAVE_SEL(SAVE_SEL),
  .SAVE_OPC_VALID(SAVE_OPC_VALID), .SAVE_DATA_REGS(SAVE_DATA_REGS),
  .LOAD_DATA_REGS(LOAD_DATA_REGS), .INIT_UNIT(INIT_UNIT));

// File: bench/flst_mem_model.sv
/* Memory holding the saved state image; writes only the fields a
   save marks as written. Assumes save strobes arrive on clk. */
`timescale 1ns/100ps
module flst_mem_model (
  input wire logic            clk,
  input wire logic            save_valid,
  input wire logic            save_off_hi,
  input wire logic            save_sel,
  input flst_pkg::flst_img_t  save_img,
  output flst_pkg::flst_img_t load_img
);
  ////////////////////////////////////////
  flst_pkg::flst_img_t mem_r = '0;
  assign load_img = mem_r;
  // unwritten fields keep old contents, so a stray write shows up later
  always_ff @(posedge clk) begin
    if (save_valid) begin
      mem_r.opcode <= save_img.opcode;
      mem_r.code.off[31:0] <= save_img.code.off[31:0];
      mem_r.opnd.off[31:0] <= save_img.opnd.off[31:0];
      if (save_off_hi) begin
        mem_r.code.off[63:32] <= save_img.code.off[63:32];
        mem_r.opnd.off[63:32] <= save_img.opnd.off[63:32];
      end
      if (save_sel) begin
        mem_r.code.sel <= save_img.code.sel;
        mem_r.opnd.sel <= save_img.opnd.sel;
      end
    end
  end
endmodule // flst_mem_model

// File: bench/test_fpu_last_instr_state_tracker.sv
/* Self-checking bench for flst_tracker with the image memory model.
   Assumes flst_pkg and the checker are compiled before this file. */
`timescale 1ns/100ps
`include "flst_consts.svh"
module test_fpu_last_instr_state_tracker;
  logic                    CORE_CLK = 1'b0;
  logic                    RST_B = 1'b0;
  logic                    RET_VALID = 1'b0;
  logic                    OP_VALID = 1'b0;
  logic                    SEL_DEPRECATE = 1'b0;
  logic                    MISC_WR = 1'b0;
  logic [`FLST_MISC_W-1:0] MISC_WDATA = '0;
  flst_pkg::flst_retire_t  RET_INFO = '0;
  flst_pkg::flst_op_t      OP_CODE = flst_pkg::FLST_OP_NONE;
  flst_pkg::flst_mode_t    OP_MODE = '0;
  flst_pkg::flst_img_t     LOAD_IMG, STATE, SAVE_IMG, a;
  flst_pkg::flst_fmt_t     SAVE_FMT;
  logic                    COMPAT_MODE, SAVE_VALID, SAVE_OFF_HI, SAVE_SEL;
  logic                    SAVE_OPC_VALID, SAVE_DATA_REGS;
  logic                    LOAD_DATA_REGS, INIT_UNIT;
  int                      bad_count = 0;
  int                      samples_checked = 0;
  ////////////////////////////////////////
  always #2 CORE_CLK = ~CORE_CLK;
  flst_tracker i_dut (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .RET_VALID(RET_VALID),
    .RET_INFO(RET_INFO), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_MODE(OP_MODE), .LOAD_IMG(LOAD_IMG), .SEL_DEPRECATE(SEL_DEPRECATE),
    .MISC_WR(MISC_WR), .MISC_WDATA(MISC_WDATA), .STATE(STATE),
    .COMPAT_MODE(COMPAT_MODE), .SAVE_VALID(SAVE_VALID), .SAVE_IMG(SAVE_IMG),
    .SAVE_FMT(SAVE_FMT), .SAVE_OFF_HI(SAVE_OFF_HI), .SAVE_SEL(SAVE_SEL),
    .SAVE_OPC_VALID(SAVE_OPC_VALID), .SAVE_DATA_REGS(SAVE_DATA_REGS),
    .LOAD_DATA_REGS(LOAD_DATA_REGS), .INIT_UNIT(INIT_UNIT));
  flst_mem_model i_mem (
    .clk(CORE_CLK), .save_valid(SAVE_VALID), .save_off_hi(SAVE_OFF_HI),
    .save_sel(SAVE_SEL), .save_img(SAVE_IMG), .load_img(LOAD_IMG));
  ////////////////////////////////////////
  task automatic check(string nm, logic [179:0] exp, logic [179:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic flst_pkg::flst_img_t shp(flst_pkg::flst_img_t i,
                                              logic hi, logic sel);
    if (!hi) begin
      i.code.off[63:32] = 32'h0;
      i.opnd.off[63:32] = 32'h0;
    end
    if (!sel) begin
      i.code.sel = 16'h0;
      i.opnd.sel = 16'h0;
    end
    return i;
  endfunction
  // first opcode byte rebuilt with its fixed upper pattern
  task automatic retire(logic ctl, logic exc, flst_pkg::flst_img_t i);
    @(posedge CORE_CLK);
    RET_VALID <= 1'b1;
    RET_INFO <= {ctl, 1'b1, exc, i.code, i.opnd, 5'h1B, i.opcode};
    @(posedge CORE_CLK);
    RET_VALID <= 1'b0;
    #1;
  endtask
  task automatic op(flst_pkg::flst_op_t c, logic [5:0] m);
    @(posedge CORE_CLK);
    OP_VALID <= 1'b1;
    OP_CODE <= c;
    OP_MODE <= m;
    @(posedge CORE_CLK);
    OP_VALID <= 1'b0;
    #1;
  endtask
  task automatic misc(logic v);
    @(posedge CORE_CLK);
    MISC_WR <= 1'b1;
    MISC_WDATA <= {61'h0, v, 2'h0};
    @(posedge CORE_CLK);
    MISC_WR <= 1'b0;
    #1;
  endtask
  task automatic save_case(flst_pkg::flst_op_t c, logic [5:0] m, logic dep,
                           logic hi, logic sel, logic [1:0] fmt);
    @(posedge CORE_CLK);
    SEL_DEPRECATE <= dep;
    op(c, m);
    check("save image", shp(a, hi, sel && !dep), SAVE_IMG);
    check("save flags", {SAVE_VALID, SAVE_OFF_HI, SAVE_SEL, SAVE_FMT},
          {1'b1, hi, sel, fmt});
  endtask
  task automatic load_case(flst_pkg::flst_op_t c, logic [5:0] m, logic hi,
                           logic sel, logic dat);
    op(c, m);
    check("loaded state", shp(a, hi, sel), STATE);
    check("data stack load", dat, LOAD_DATA_REGS);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (1000) @(posedge CORE_CLK);
    bad_count++;
    finish_test();
  end
  initial begin
    a = {16'h1234, 64'hA1B2C3D4E5F60718, 16'h5678, 64'h0F1E2D3C4B5A6978,
         11'h5C9};
    repeat (3) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    retire(1'b0, 1'b0, a);
    check("capture", a, STATE);
    retire(1'b1, 1'b0, ~a);
    check("control kept", a, STATE);
    for (int k = 11; k < 16; k++) begin
      op(flst_pkg::flst_op_t'(k), 6'h21);
      check("transparent", a, STATE);
    end
    $display("capture test done");
    save_case(flst_pkg::FLST_OP_ENV_STORE, 6'h21, 1'b0, 1'b0, 1'b1, 2'h0);
    save_case(flst_pkg::FLST_OP_ENV_STORE, 6'h05, 1'b0, 1'b0, 1'b0, 2'h2);
    save_case(flst_pkg::FLST_OP_ENV_STORE, 6'h25, 1'b0, 1'b0, 1'b1, 2'h2);
    save_case(flst_pkg::FLST_OP_EXTENDED_SAVE_ALT_OP, 6'h21, 1'b1, 1'b0, 1'b1, 2'h0);
    save_case(flst_pkg::FLST_OP_EXTENDED_SAVE_ALT_OP_ALT, 6'h39, 1'b1, 1'b1, 1'b0, 2'h0);
    save_case(flst_pkg::FLST_OP_EXTENDED_SAVE_ALT_OP_OPT, 6'h18, 1'b0, 1'b1, 1'b0, 2'h3);
    save_case(flst_pkg::FLST_OP_FULL_SAVE, 6'h21, 1'b0, 1'b0, 1'b1, 2'h0);
    check("cleared", 2'h3, {STATE, SAVE_DATA_REGS, INIT_UNIT});
    $display("save test done");
    // memory takes the image one edge after the save strobe
    @(posedge CORE_CLK);
    #1;
    check("image memory", a, LOAD_IMG);
    load_case(flst_pkg::FLST_OP_ENV_LOAD, 6'h01, 1'b0, 1'b0, 1'b0);
    load_case(flst_pkg::FLST_OP_FULL_RST, 6'h21, 1'b0, 1'b1, 1'b1);
    load_case(flst_pkg::FLST_OP_XRST, 6'h39, 1'b1, 1'b0, 1'b0);
    load_case(flst_pkg::FLST_OP_XRST_ALT, 6'h31, 1'b0, 1'b1, 1'b0);
    op(flst_pkg::FLST_OP_INIT, 6'h21);
    check("init", 1'b1, {STATE, INIT_UNIT});
    $display("load test done");
    misc(1'b1);
    check("compat on", 1'b1, COMPAT_MODE);
    retire(1'b0, 1'b0, a);
    op(flst_pkg::FLST_OP_ENV_STORE, 6'h21);
    check("opcode valid", 1'b1, SAVE_OPC_VALID);
    misc(1'b0);
    op(flst_pkg::FLST_OP_ENV_STORE, 6'h21);
    check("opcode invalid", 1'b0, SAVE_OPC_VALID);
    retire(1'b0, 1'b1, a);
    op(flst_pkg::FLST_OP_ENV_STORE, 6'h21);
    check("opcode on fault", 1'b1, SAVE_OPC_VALID);
    $display("opcode test done");
    finish_test();
  end
endmodule // test_fpu_last_instr_state_tracker
